/* design/dram_ctrl_pkg.sv */
// constants for the dram timing and control core
// assumes a 40 MHz system clock; times are in ns
package dram_ctrl_pkg;

	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned CNT_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned LANES = 4;
	localparam int unsigned RD_FIFO_DEPTH = 8;
	localparam int unsigned WARMUP_DEFAULT = 8;
	localparam int unsigned WARM_W = 8;
	localparam int unsigned NIBBLE_WORDS = 4;

	// dram timing figures
	localparam int unsigned T_ROW_HOLD_NS = 15;
	localparam int unsigned T_RAS_PRE_NS = 80;
	localparam int unsigned T_CAS_ACC_NS = 50;
	localparam int unsigned T_CAS_PRE_NS = 15;
	localparam int unsigned T_CAS_SETUP_NS = 10;
	localparam int unsigned T_REF_RAS_NS = 100;

	// least times, rounded up to whole cycles
	localparam logic [CNT_W-1:0] ROW_HOLD_CYC =
		CNT_W'((T_ROW_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] RAS_PRE_CYC =
		CNT_W'((T_RAS_PRE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] CAS_ACC_CYC =
		CNT_W'((T_CAS_ACC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] CAS_PRE_CYC =
		CNT_W'((T_CAS_PRE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] CAS_SETUP_CYC =
		CNT_W'((T_CAS_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] REF_RAS_CYC =
		CNT_W'((T_REF_RAS_NS * CLK_MHZ + 999) / 1000);

endpackage

/* design/dram_static_column_ctrl.sv */
// dram timing and control core with read data fifo
// assumes bus inputs are synchronous to clk_sys and byte enables latched
//
// How it works
// (R1) ras, byte cas and we are sequenced; wordDone pulses per word
// (R2) refresh drives all cas low before ras when refresh is selected
// (R3) refresh needs no row address; the dram counts rows itself
// (R4) after reset a series of warm-up refreshes runs first
// (R5) work starts on busCycleActive; memSelect picks access or refresh
// (R6) read: row select high, ras low, column select, byte cas, wordDone
// (R7) burst logic advances column and processor takes word on wordDone; read words go into the read fifo, popped via rdValid/rdReady
// (R8) after each word sample busCycleActive; repulse cas or release ras
// (R9) write: we low first, then the same steps as a read
// (R10) one ras, four cas each from its latched byte lane enable
// (R11) partial writes use one we and per-lane cas only
// (R12) nibble mode toggles cas for at most four words
// (R13) static column burst keeps ras low, only column changes
// (R14) column select only after row address hold time after ras falls
// (R15) no new cycle until ras precharge time has passed
// (R16) optional even/odd word banks hide precharge on sequential access
// (R17) idle cycles let the last bank precharge
// (R18) arbiter drives memSelect from chip select, activity, refresh
// (R19) refresh only served after the current bus operation ends
// (R20) address mux follows rowColSel
// (R21) warm-up count is a parameter, default eight; accesses wait
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module read_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} fifo_s;

	fifo_s s_r;
	fifo_s s_nxt;
	logic full;
	logic empty;

	assign empty = s_r.wp == s_r.rp;
	assign full = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) &&
		(s_r.wp[AW] != s_r.rp[AW]);
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = s_r.mem[s_r.rp[AW-1:0]];

	always_comb begin
		s_nxt = s_r;
		if (inValid && !full) begin
			s_nxt.mem[s_r.wp[AW-1:0]] = inData;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (outReady && !empty) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
module dram_static_column_ctrl #(
	parameter int unsigned WARMUP = dram_ctrl_pkg::WARMUP_DEFAULT,
	parameter bit INTERLEAVE = 1'b0,
	parameter int unsigned FIFO_DEPTH = dram_ctrl_pkg::RD_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic memSelect,
	input wire logic busCycleActive,
	input wire logic writeRead,
	input wire logic wordAddrOdd,
	input wire logic nibbleMode,
	input wire logic [dram_ctrl_pkg::LANES-1:0] byteLaneEnable,
	input wire logic [dram_ctrl_pkg::DATA_W-1:0] wrData,
	input wire logic [dram_ctrl_pkg::DATA_W-1:0] dramDataIn,
	output logic [dram_ctrl_pkg::DATA_W-1:0] dramDataOut,
	output logic dramDataOe_n,
	output logic [1:0] ras_n,
	output logic [dram_ctrl_pkg::LANES-1:0] cas_n,
	output logic we_n,
	output logic rowColSel,
	output logic wordDone,
	output logic warmupBusy,
	output logic rdValid,
	input wire logic rdReady,
	output logic [dram_ctrl_pkg::DATA_W-1:0] rdData
);
	localparam int unsigned CW = dram_ctrl_pkg::CNT_W;
	localparam int unsigned WW = dram_ctrl_pkg::WARM_W;
	localparam int unsigned DW = dram_ctrl_pkg::DATA_W;
	localparam int unsigned LN = dram_ctrl_pkg::LANES;
	localparam logic [2:0] NIB_MAX = 3'(dram_ctrl_pkg::NIBBLE_WORDS);

	typedef enum logic [10:0] {
		S_IDLE = 11'h001,
		S_REF_CAS = 11'h002,
		S_REF_RAS = 11'h004,
		S_WR_SETUP = 11'h008,
		S_ROW = 11'h010,
		S_RAS_ON = 11'h020,
		S_COL = 11'h040,
		S_CAS_ON = 11'h080,
		S_DONE = 11'h100,
		S_CAS_PRE = 11'h200,
		S_CLOSE = 11'h400
	} state_e;

	typedef struct packed {
		state_e st;
		logic [CW-1:0] cnt;
		logic [WW-1:0] warmLeft;
		logic [2:0] words;
		logic writeOp;
		logic bank;
		logic [1:0][CW-1:0] pre;
		logic [1:0] rasN;
		logic [LN-1:0] casN;
		logic weN;
		logic rowCol;
		logic done;
		logic oeN;
		logic [DW-1:0] dOut;
	} ctrl_s;

	ctrl_s s_r;
	ctrl_s s_nxt;
	logic bankNow;
	logic bothPre;
	logic fifoPush;
	logic fifoInReady;

	assign bankNow = INTERLEAVE ? wordAddrOdd : 1'b0;
	assign bothPre = (s_r.pre[0] == '0) && (s_r.pre[1] == '0);

	////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		s_nxt = s_r;
		fifoPush = 1'b0;
		if (s_r.cnt != '0) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
		// (R17) idle precharge countdown
		for (int b = 0; b < 2; b++) begin
			if (s_r.pre[b] != '0) begin
				s_nxt.pre[b] = s_r.pre[b] - 1'b1;
			end
		end
		case (s_r.st)
			S_IDLE: begin
				// (R4) (R21) warm-up refreshes first
				if (s_r.warmLeft != '0) begin
					if (bothPre) begin
						s_nxt.warmLeft = s_r.warmLeft - 1'b1;
						s_nxt.st = S_REF_CAS;
						s_nxt.cnt = dram_ctrl_pkg::CAS_SETUP_CYC - 1'b1;
					end
				// (R5) (R2) refresh selected
				end else if (busCycleActive && !memSelect) begin
					if (bothPre) begin
						s_nxt.st = S_REF_CAS;
						s_nxt.cnt = dram_ctrl_pkg::CAS_SETUP_CYC - 1'b1;
					end
				// (R15) (R16) access waits for its bank
				end else if (busCycleActive && memSelect) begin
					if (s_r.pre[bankNow] == '0) begin
						s_nxt.writeOp = writeRead;
						s_nxt.bank = bankNow;
						s_nxt.words = '0;
						s_nxt.st = writeRead ? S_WR_SETUP : S_ROW;
					end
				end
			end
			// (R2) (R3) cas before ras refresh
			S_REF_CAS: begin
				if (s_r.cnt == '0) begin
					s_nxt.st = S_REF_RAS;
					s_nxt.cnt = dram_ctrl_pkg::REF_RAS_CYC - 1'b1;
				end
			end
			S_REF_RAS: begin
				if (s_r.cnt == '0) begin
					s_nxt.st = S_CLOSE;
					// (R15) both banks precharge
					s_nxt.pre[0] = dram_ctrl_pkg::RAS_PRE_CYC;
					s_nxt.pre[1] = dram_ctrl_pkg::RAS_PRE_CYC;
				end
			end
			// (R9) we leads the row phase
			S_WR_SETUP: begin
				s_nxt.st = S_ROW;
			end
			// (R6) row select, then ras
			S_ROW: begin
				s_nxt.st = S_RAS_ON;
				s_nxt.cnt = dram_ctrl_pkg::ROW_HOLD_CYC - 1'b1;
			end
			// (R14) hold row address
			S_RAS_ON: begin
				if (s_r.cnt == '0) begin
					s_nxt.st = S_COL;
				end
			end
			S_COL: begin
				s_nxt.st = S_CAS_ON;
				s_nxt.cnt = dram_ctrl_pkg::CAS_ACC_CYC - 1'b1;
			end
			S_CAS_ON: begin
				if (s_r.cnt == '0 && (s_r.writeOp || fifoInReady)) begin
					s_nxt.st = S_DONE;
				end
			end
			// (R1) (R7) word completes
			S_DONE: begin
				fifoPush = !s_r.writeOp;
				s_nxt.words = s_r.words + 1'b1;
				s_nxt.st = S_CAS_PRE;
				s_nxt.cnt = dram_ctrl_pkg::CAS_PRE_CYC - 1'b1;
			end
			// (R8) (R12) (R13) next burst word or close
			S_CAS_PRE: begin
				if (s_r.cnt == '0) begin
					if (busCycleActive && memSelect &&
						(!nibbleMode || s_r.words != NIB_MAX)) begin
						s_nxt.st = S_CAS_ON;
						s_nxt.cnt = dram_ctrl_pkg::CAS_ACC_CYC - 1'b1;
					end else begin
						s_nxt.st = S_CLOSE;
					end
				end
			end
			// (R15) start ras precharge
			S_CLOSE: begin
				s_nxt.st = S_IDLE;
				s_nxt.pre[s_r.bank] = dram_ctrl_pkg::RAS_PRE_CYC - 1'b1;
			end
			default: begin
				s_nxt.st = S_IDLE;
			end
		endcase

		// (R1) (R10) (R11) pin levels from next state
		s_nxt.rasN = 2'h3;
		if (s_nxt.st == S_REF_RAS) begin
			s_nxt.rasN = 2'h0;
		end else if (s_nxt.st inside {S_RAS_ON, S_COL, S_CAS_ON,
			S_DONE, S_CAS_PRE}) begin
			s_nxt.rasN[s_nxt.bank] = 1'b0;
		end
		s_nxt.casN = '1;
		if (s_nxt.st inside {S_REF_CAS, S_REF_RAS}) begin
			s_nxt.casN = '0;
		end else if (s_nxt.st inside {S_CAS_ON, S_DONE}) begin
			s_nxt.casN = ~byteLaneEnable;
		end
		s_nxt.weN = !(s_nxt.writeOp && (s_nxt.st inside {S_WR_SETUP,
			S_ROW, S_RAS_ON, S_COL, S_CAS_ON, S_DONE, S_CAS_PRE}));
		s_nxt.oeN = s_nxt.weN;
		s_nxt.rowCol = s_nxt.st inside {S_ROW, S_RAS_ON};
		s_nxt.done = s_nxt.st == S_DONE;
		s_nxt.dOut = wrData;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{st: S_IDLE, cnt: '0, warmLeft: WW'(WARMUP),
				words: '0, writeOp: 1'b0, bank: 1'b0, pre: '0,
				rasN: 2'h3, casN: '1, weN: 1'b1, rowCol: 1'b0,
				done: 1'b0, oeN: 1'b1, dOut: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ras_n = s_r.rasN;
	assign cas_n = s_r.casN;
	assign we_n = s_r.weN;
	assign rowColSel = s_r.rowCol;
	assign wordDone = s_r.done;
	assign dramDataOe_n = s_r.oeN;
	assign dramDataOut = s_r.dOut;
	assign warmupBusy = s_r.warmLeft != '0;

	////////////////////////////////////////////////////////////////////
	// read data buffer
	read_fifo #(
		.WIDTH(DW),
		.DEPTH(FIFO_DEPTH)
	) u_rd_fifo (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData(dramDataIn),
		.outValid(rdValid),
		.outReady(rdReady),
		.outData(rdData)
	);

	////////////////////////////////////////////////////////////////////
	// checks
	logic [CW-1:0] highCnt;
	logic rasLow;
	assign rasLow = !ras_n[0];

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			highCnt <= '1;
		end else if (rasLow) begin
			highCnt <= '0;
		end else if (highCnt != '1) begin
			highCnt <= highCnt + 1'b1;
		end
	end

	property p_precharge;
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(ras_n[0]) |-> highCnt >= dram_ctrl_pkg::RAS_PRE_CYC;
	endproperty
	a_precharge: assert property (p_precharge) // (R15)
		else $error("ras precharge too short");

	property p_cbr;
		@(posedge clk_sys) disable iff (!reset_n)
		($fell(ras_n[0]) && cas_n == '0) |-> $past(cas_n == '0);
	endproperty
	a_cbr: assert property (p_cbr) // (R2)
		else $error("refresh cas not ahead of ras");

	property p_row_first;
		@(posedge clk_sys) disable iff (!reset_n)
		($fell(ras_n[0]) && cas_n == '1) |-> rowColSel && $past(rowColSel);
	endproperty
	a_row_first: assert property (p_row_first) // (R6)
		else $error("ras fell without row select");

	property p_row_hold;
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(rowColSel) |-> rasLow && $past(rasLow);
	endproperty
	a_row_hold: assert property (p_row_hold) // (R14)
		else $error("column select before row hold");

	property p_word;
		@(posedge clk_sys) disable iff (!reset_n)
		wordDone |-> rasLow && !rowColSel && cas_n != '1 ##1 cas_n == '1;
	endproperty
	a_word: assert property (p_word) // (R1)
		else $error("word done with bad strobes");

	property p_lanes;
		@(posedge clk_sys) disable iff (!reset_n)
		wordDone |-> (~cas_n & ~$past(byteLaneEnable)) == '0;
	endproperty
	a_lanes: assert property (p_lanes) // (R10)
		else $error("cas on an unselected lane");

	property p_we_first;
		@(posedge clk_sys) disable iff (!reset_n)
		$fell(we_n) |-> ras_n == 2'h3 ##1 rowColSel;
	endproperty
	a_we_first: assert property (p_we_first) // (R9)
		else $error("we not ahead of ras");

	property p_warm;
		@(posedge clk_sys) disable iff (!reset_n)
		warmupBusy |-> !wordDone && we_n;
	endproperty
	a_warm: assert property (p_warm) // (R21)
		else $error("access during warm-up");

	property p_nibble;
		@(posedge clk_sys) disable iff (!reset_n)
		(wordDone && nibbleMode) |-> s_r.words < NIB_MAX;
	endproperty
	a_nibble: assert property (p_nibble) // (R12)
		else $error("nibble burst too long");

	property p_burst;
		@(posedge clk_sys) disable iff (!reset_n)
		(wordDone && rasLow) |=> rasLow && !rowColSel;
	endproperty
	a_burst: assert property (p_burst) // (R13)
		else $error("row closed inside word");
endmodule

/* verif/local_bus_model.sv */
// partner model: bus master, burst address logic, refresh arbiter, dram data
// assumes the controller's strobes are registered on clk_sys
`timescale 1ns/1ps

module local_bus_model (
	input wire logic clk_sys,
	input wire logic [1:0] ras_n,
	input wire logic [3:0] cas_n,
	input wire logic we_n,
	input wire logic rowColSel,
	input wire logic wordDone,
	output logic busCycleActive,
	output logic memSelect,
	output logic writeRead,
	output logic [31:0] dramDataIn
);
	logic [7:0] colAddr = 8'h00;
	logic [31:0] pattern;

	initial begin
		busCycleActive = 1'b0;
		memSelect = 1'b1;
		writeRead = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// column advances per word
	always @(posedge clk_sys) begin
		if (wordDone)
			colAddr <= colAddr + 8'h01;
	end

	// mux shows column address only while rowColSel is low
	assign pattern = 32'hc0de0000 + {24'h000000, colAddr};
	assign dramDataIn = (cas_n != 4'hf && we_n && !rowColSel) ?
		pattern : ~pattern;

	////////////////////////////////////////////////////////////////////////
	// memory request held to last word
	task automatic access(input logic wr, input logic [7:0] col, input int n);
		int cnt = 0;
		int guard = 0;
		@(posedge clk_sys);
		#1;
		colAddr = col;
		writeRead = wr;
		memSelect = 1'b1;
		busCycleActive = 1'b1;
		while (busCycleActive && guard < 600) begin
			@(posedge clk_sys);
			#1;
			guard++;
			if (wordDone)
				cnt++;
			// a burst cut short closes ras after a word
			if (cnt == n || (cnt > 0 && ras_n[0]))
				busCycleActive = 1'b0;
		end
		// keep the request low through the next-word decision
		@(posedge clk_sys);
		#1;
		busCycleActive = 1'b0;
	endtask

	task automatic refresh();
		int guard = 0;
		@(posedge clk_sys);
		#1;
		memSelect = 1'b0;
		busCycleActive = 1'b1;
		while (busCycleActive && guard < 100) begin
			@(posedge clk_sys);
			#1;
			guard++;
			if (cas_n == 4'h0) begin
				busCycleActive = 1'b0;
				memSelect = 1'b1;
			end
		end
	endtask
endmodule

/* verif/tb.sv */
// testbench for the dram timing and control core
// assumes local_bus_model as far side; warm-up shortened to two
`timescale 1ns/1ps

module tb;
	localparam int WARM = 2;
	localparam int FIFO = 8;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic nibbleMode = 1'b0;
	logic rdReady = 1'b0;
	logic wordAddrOdd = 1'b0;
	logic [3:0] byteLaneEnable = 4'hf;
	logic [31:0] wrData = 32'h00000000;
	logic busCycleActive, memSelect, writeRead, dramDataOe_n, we_n;
	logic rowColSel, wordDone, warmupBusy, rdValid;
	logic [31:0] dramDataIn, dramDataOut, rdData;
	logic [1:0] ras_n;
	logic [3:0] cas_n;
	logic [3:0] lanesExp = 4'hf;
	logic writeExp = 1'b0;
	logic prevRas = 1'b1;
	logic prevDone = 1'b0;
	int bad_count = 0;
	int comparisons = 0;
	int wordCount = 0;
	int refCount = 0;
	int hiCnt = 100;

	always #12.5 clk_sys = ~clk_sys;

	dram_static_column_ctrl #(.WARMUP(WARM), .FIFO_DEPTH(FIFO))
		dram_static_column_ctrl_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.memSelect(memSelect), .busCycleActive(busCycleActive),
		.writeRead(writeRead), .wordAddrOdd(wordAddrOdd),
		.nibbleMode(nibbleMode), .byteLaneEnable(byteLaneEnable),
		.wrData(wrData), .dramDataIn(dramDataIn), .dramDataOut(dramDataOut),
		.dramDataOe_n(dramDataOe_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .rowColSel(rowColSel), .wordDone(wordDone),
		.warmupBusy(warmupBusy), .rdValid(rdValid), .rdReady(rdReady),
		.rdData(rdData));

	local_bus_model local_bus_model_inst (.clk_sys(clk_sys), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .rowColSel(rowColSel),
		.wordDone(wordDone),
		.busCycleActive(busCycleActive), .memSelect(memSelect),
		.writeRead(writeRead), .dramDataIn(dramDataIn));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// strobe watcher, sampled mid-cycle
	always @(negedge clk_sys) begin
		if (prevRas && !ras_n[0]) begin
			if (cas_n === 4'h0) begin
				check(ras_n, 2'b00);
				refCount++;
			end else begin
				check({rowColSel, cas_n, we_n}, {1'b1, 4'hf, ~writeExp});
			end
			check(hiCnt >= dram_ctrl_pkg::RAS_PRE_CYC, 1'b1);
			hiCnt = 0;
		end
		if (ras_n[0])
			hiCnt++;
		if (wordDone) begin
			wordCount++;
			check({ras_n[0], rowColSel, warmupBusy}, 3'b000);
			check(cas_n, 4'(~lanesExp));
			check({we_n, dramDataOe_n}, {~writeExp, ~writeExp});
			if (writeExp)
				check(dramDataOut, wrData);
		end
		if (prevDone)
			check(cas_n, 4'hf);
		prevDone = wordDone;
		prevRas = ras_n[0];
	end

	task automatic popCheck(input int n, input logic [7:0] col);
		int k = 0;
		int guard = 0;
		rdReady = 1'b1;
		while (k < n && guard < 400) begin
			@(negedge clk_sys);
			guard++;
			if (rdValid === 1'b1) begin
				check(rdData, 32'hc0de0000 + 32'(col) + 32'(k));
				k++;
			end
		end
		@(posedge clk_sys);
		#1;
		rdReady = 1'b0;
		check(rdValid, 1'b0);
		check(k, n);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic testResetWarmup();
		check({ras_n, cas_n, we_n, rowColSel, wordDone}, 9'h1fc);
		check({dramDataOe_n, warmupBusy, rdValid}, 3'b110);
		reset_n = 1'b1;
		local_bus_model_inst.access(1'b0, 8'h10, 1);
		check(refCount, WARM);
		popCheck(1, 8'h10);
		$display("reset and warm-up test done");
	endtask

	task automatic testReadLanes();
		for (int i = 0; i < 4; i++) begin
			lanesExp = 4'h1 << i;
			byteLaneEnable = lanesExp;
			local_bus_model_inst.access(1'b0, 8'h20 + 8'(i), 1);
		end
		popCheck(4, 8'h20);
		$display("byte lane read test done");
	endtask

	task automatic testWriteBurst();
		int w0 = wordCount;
		writeExp = 1'b1;
		lanesExp = 4'h6;
		byteLaneEnable = lanesExp;
		wrData = 32'h13579bdf;
		local_bus_model_inst.access(1'b1, 8'h40, 3);
		check(wordCount - w0, 3);
		writeExp = 1'b0;
		lanesExp = 4'hf;
		byteLaneEnable = lanesExp;
		$display("write burst test done");
	endtask

	task automatic testRefresh();
		int r0 = refCount;
		int w0 = wordCount;
		local_bus_model_inst.refresh();
		repeat (10) @(posedge clk_sys);
		#1;
		check(refCount - r0, 1);
		check(wordCount - w0, 0);
		$display("refresh test done");
	endtask

	task automatic testNibble();
		int w0 = wordCount;
		nibbleMode = 1'b1;
		local_bus_model_inst.access(1'b0, 8'h60, 6);
		check(wordCount - w0, dram_ctrl_pkg::NIBBLE_WORDS);
		nibbleMode = 1'b0;
		popCheck(4, 8'h60);
		$display("nibble test done");
	endtask

	task automatic testFifoFull();
		int w0 = wordCount;
		fork
			local_bus_model_inst.access(1'b0, 8'h80, 10);
			begin
				repeat (80) @(posedge clk_sys);
				@(negedge clk_sys);
				check(wordCount - w0, FIFO);
				check(cas_n, 4'h0);
				@(posedge clk_sys);
				#1;
				popCheck(10, 8'h80);
			end
		join
		$display("fifo full test done");
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		#1;
		testResetWarmup();
		testReadLanes();
		testWriteBurst();
		testRefresh();
		testNibble();
		testFifoFull();
		repeat (10) @(posedge clk_sys);
		results();
	end

	initial begin
		repeat (6000) @(posedge clk_sys);
		bad_count++;
		results();
	end
endmodule
